// ### pitc_defines.vh
// constants for the per-port ingress priority and tag control bank
// assumes the switch core clock and the management register port
// Notes on behaviour
// - Bit 7 set enables broadcast storm protection on that port's ingress.
// - Bit 6 set enables DiffServ priority classification on ingress.
// - Bit 5 set enables 802.1p user priority classification on ingress.
// - Bits 4-3 give queue 0-3 when neither classifier is on or hits, reset 0.
// - DiffServ and 802.1p results are OR'ed and override the port priority.
// - Bit 2 on an output port adds a tag to packets that arrived untagged.
// - The inserted tag carries the default VID of the ingress port.
// - Bit 1 on an output port strips the tag of packets that arrived tagged.
// - Queue mode is global bit (upper) joined with port bit 0 (lower).
// - Code 10 is four queues, 01 two, 00 one, 11 reserved for software.
// - The default tag high byte holds priority, CFI, VID 11-8; low VID 7-0.
`ifndef PITC_DEFINES_VH
`define PITC_DEFINES_VH
`define PITC_OFS_PORT1     8'h20
`define PITC_OFS_PORT2     8'h30
`define PITC_OFS_PORT3     8'h40
`define PITC_OFS_PORT4     8'h50
`define PITC_OFS_STRIDE    8'h10
`define PITC_CTL_RESET     8'h00
`define PITC_BIT_STORM     7
`define PITC_BIT_DSCP      6
`define PITC_BIT_DOT1P     5
`define PITC_BIT_PRI_HI    4
`define PITC_BIT_PRI_LO    3
`define PITC_BIT_TAG_INS   2
`define PITC_BIT_TAG_REM   1
`define PITC_BIT_QSPLIT    0
`define PITC_QMODE_ONE     2'h0
`define PITC_QMODE_TWO     2'h1
`define PITC_QMODE_FOUR    2'h2
`define PITC_QMODE_RSVD    2'h3
`define PITC_TAG_VIDHI_HI  3
`define PITC_TAG_VIDHI_LO  0
`endif

// ### pitc_port_control.v
// four per-port ingress control registers and the decisions they steer
// assumes all event inputs come from switch core logic on clk_sys
`timescale 1ns/1ns
`include "pitc_defines.vh"
module pitc_port_control (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  output reg         reg_rvalid,
  input  wire [3:0]  glb_qsplit,
  input  wire [31:0] dflt_tag_hi,
  input  wire [31:0] dflt_tag_lo,
  input  wire        rx_valid,
  input  wire [1:0]  rx_port,
  input  wire        rx_bcast,
  input  wire        rx_storm_over,
  input  wire        rx_dscp_hit,
  input  wire [1:0]  rx_dscp_pri,
  input  wire        rx_dot1p_hit,
  input  wire [1:0]  rx_dot1p_pri,
  output reg         cls_valid,
  output reg         cls_drop,
  output reg  [1:0]  cls_pri,
  input  wire        eg_valid,
  input  wire [1:0]  eg_src_port,
  input  wire [1:0]  eg_dst_port,
  input  wire        eg_rx_tagged,
  output reg         eg_res_valid,
  output reg         eg_add_tag,
  output reg         eg_strip_tag,
  output reg  [11:0] eg_vid,
  output reg  [7:0]  qmode
);

  wire [31:0] ctl_all;
  wire [3:0]  hit;
  wire [7:0]  ctl_rx;
  wire [7:0]  ctl_eg;
  wire [7:0]  tag_hi;
  wire [7:0]  tag_lo;
  wire [7:0]  qmode_d;
  reg  [7:0]  rdata_d;
  reg  [1:0]  pri_d;
  reg  [1:0]  or_pri;
  reg         any_hit;
  integer     i;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_port
      reg [7:0] ctl_q;
      assign hit[g] = (reg_addr == `PITC_OFS_PORT1 +
                       `PITC_OFS_STRIDE * g);
      always @(posedge clk_sys) begin
        if (!rst_n) begin
          ctl_q <= `PITC_CTL_RESET;
        end else if (reg_wr && hit[g]) begin
          ctl_q <= reg_wdata;
        end
      end
      assign ctl_all[8*g+7:8*g] = ctl_q;
      // global bit above, port bit below
      assign qmode_d[2*g+1:2*g] = {glb_qsplit[g],
                                   ctl_q[`PITC_BIT_QSPLIT]};
    end
  endgenerate

  assign ctl_rx = ctl_all[8*rx_port +: 8];
  assign ctl_eg = ctl_all[8*eg_dst_port +: 8];
  assign tag_hi = dflt_tag_hi[8*eg_src_port +: 8];
  assign tag_lo = dflt_tag_lo[8*eg_src_port +: 8];

  always @* begin
    rdata_d = 8'h00;
    for (i = 0; i < 4; i = i + 1) begin
      if (hit[i]) begin
        rdata_d = ctl_all[8*i +: 8];
      end
    end
  end

  // combined classifier result beats the port fallback
  always @* begin
    any_hit = 1'b0;
    or_pri  = 2'h0;
    if (ctl_rx[`PITC_BIT_DSCP] && rx_dscp_hit) begin
      any_hit = 1'b1;
      or_pri  = or_pri | rx_dscp_pri;
    end
    if (ctl_rx[`PITC_BIT_DOT1P] && rx_dot1p_hit) begin
      any_hit = 1'b1;
      or_pri  = or_pri | rx_dot1p_pri;
    end
    if (any_hit) begin
      pri_d = or_pri;
    end else begin
      pri_d = ctl_rx[`PITC_BIT_PRI_HI:`PITC_BIT_PRI_LO];
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata    <= 8'h00;
      reg_rvalid   <= 1'b0;
      cls_valid    <= 1'b0;
      cls_drop     <= 1'b0;
      cls_pri      <= 2'h0;
      eg_res_valid <= 1'b0;
      eg_add_tag   <= 1'b0;
      eg_strip_tag <= 1'b0;
      eg_vid       <= 12'h000;
      qmode        <= 8'h00;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
      qmode     <= qmode_d;
      cls_valid <= rx_valid;
      if (rx_valid) begin
        cls_pri  <= pri_d;
        cls_drop <= ctl_rx[`PITC_BIT_STORM] && rx_bcast &&
                    rx_storm_over;
      end
      eg_res_valid <= eg_valid;
      if (eg_valid) begin
        eg_add_tag   <= ctl_eg[`PITC_BIT_TAG_INS] && !eg_rx_tagged;
        eg_strip_tag <= ctl_eg[`PITC_BIT_TAG_REM] && eg_rx_tagged;
        // vid from the ingress port's default tag
        eg_vid <= {tag_hi[`PITC_TAG_VIDHI_HI:`PITC_TAG_VIDHI_LO],
                   tag_lo};
      end
    end
  end

endmodule

// ### pitc_port_control_sva.sv
// handshake and tag decision checks for the port control bank
// assumes one clock and synchronous active-low reset
`timescale 1ns/1ns
module pitc_port_control_sva (
  input wire       clk_sys,
  input wire       rst_n,
  input wire       reg_rd,
  input wire       reg_rvalid,
  input wire       rx_valid,
  input wire       cls_valid,
  input wire [1:0] cls_pri,
  input wire       eg_valid,
  input wire       eg_res_valid,
  input wire       eg_add_tag,
  input wire       eg_strip_tag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read answer missing");
  rd_quiet_a: assert property (!reg_rd |=> !reg_rvalid)
    else $error("stray read answer");
  cls_answer_a: assert property (rx_valid |=> cls_valid)
    else $error("class answer missing");
  cls_quiet_a: assert property (!rx_valid |=> !cls_valid)
    else $error("stray class answer");
  pri_hold_a: assert property (!rx_valid |=> $stable(cls_pri))
    else $error("queue changed unasked");
  eg_answer_a: assert property (eg_valid |=> eg_res_valid)
    else $error("egress answer missing");
  eg_quiet_a: assert property (!eg_valid |=> !eg_res_valid)
    else $error("stray egress answer");
  tag_excl_a: assert property (!(eg_add_tag && eg_strip_tag))
    else $error("add and strip together");
endmodule
bind pitc_port_control pitc_port_control_sva pitc_port_control_sva_i (
  .clk_sys, .rst_n, .reg_rd, .reg_rvalid, .rx_valid, .cls_valid, .cls_pri,
  .eg_valid, .eg_res_valid, .eg_add_tag, .eg_strip_tag);

// ### pitc_port_control_tb.sv
// random self-checking bench for the port control bank
// assumes answers one cycle after each strobe
`timescale 1ns/1ns
module pitc_port_control_tb;
  reg clk_sys = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  reg rx_valid = 1'h0, rx_bcast = 1'h0, rx_storm_over = 1'h0;
  reg rx_dscp_hit = 1'h0, rx_dot1p_hit = 1'h0, eg_valid = 1'h0;
  reg eg_rx_tagged = 1'h0;
  reg [1:0] rx_port = 2'h0, rx_dscp_pri = 2'h0, rx_dot1p_pri = 2'h0;
  reg [1:0] eg_src_port = 2'h0, eg_dst_port = 2'h0;
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, c, ctl [0:3];
  reg [3:0] glb_qsplit = 4'h0;
  reg [31:0] dflt_tag_hi = 32'h0, dflt_tag_lo = 32'h0, st = 32'hcf28, r;
  wire [7:0] reg_rdata, qmode;
  wire [11:0] eg_vid;
  wire [1:0] cls_pri;
  wire reg_rvalid, cls_valid, cls_drop, eg_res_valid, eg_add_tag;
  wire eg_strip_tag;
  integer bad_count = 0, comparisons = 0, i, p, s, d;
  pitc_port_control pitc_port_control_i (.*);
  always #5 clk_sys = ~clk_sys;
  function [31:0] xs;
    begin
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      xs = st;
    end
  endfunction
  function [1:0] epri(input [7:0] k);
    begin
      epri = (k[6] & rx_dscp_hit ? rx_dscp_pri : 2'h0)
           | (k[5] & rx_dot1p_hit ? rx_dot1p_pri : 2'h0);
      if (!(k[6] & rx_dscp_hit | k[5] & rx_dot1p_hit)) epri = k[4:3];
    end
  endfunction
  task ck(input [31:0] g, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task complete_run;
    begin
      $display("bad_count %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #5000;
    bad_count = bad_count + 1;
    complete_run;
  end
  initial begin
    for (p = 0; p < 4; p = p + 1) ctl[p] = 8'h00;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'h1;
    for (i = 0; i < 60; i = i + 1) begin
      r = xs();
      p = r[1:0];
      d = i < 2 ? 8'hff * i : r[15:8];
      @(posedge clk_sys);
      reg_wr <= 1'h1;
      reg_addr <= i % 8 == 5 ? 8'h10 : 8'h20 + 8'h10 * p;
      reg_wdata <= d;
      {glb_qsplit, dflt_tag_hi} <= {r[19:16], xs()};
      dflt_tag_lo <= xs();
      @(posedge clk_sys);
      if (i % 8 != 5) ctl[p] = d;
      r = xs();
      {reg_wr, reg_rd, rx_valid, eg_valid} <= 4'h7;
      {rx_bcast, rx_storm_over, rx_dscp_hit, rx_dot1p_hit, rx_port,
       rx_dscp_pri, rx_dot1p_pri, eg_src_port, eg_dst_port,
       eg_rx_tagged} <= r[16:0];
      @(posedge clk_sys);
      {reg_rd, rx_valid, eg_valid} <= 3'h0;
      #1;
      ck(reg_rdata, i % 8 == 5 ? 0 : d);
      ck({reg_rvalid, cls_valid, eg_res_valid}, 3'h7);
      c = ctl[rx_port];
      ck(cls_pri, epri(c));
      ck(cls_drop, c[7] & rx_bcast & rx_storm_over);
      c = ctl[eg_dst_port];
      ck(eg_add_tag, c[2] & !eg_rx_tagged);
      ck(eg_strip_tag, c[1] & eg_rx_tagged);
      s = eg_src_port;
      ck(eg_vid, {dflt_tag_hi[8*s+:4], dflt_tag_lo[8*s+:8]});
      for (p = 0; p < 4; p = p + 1) begin
        ck(qmode[2*p+:2], {glb_qsplit[p], ctl[p][0]});
      end
    end
    complete_run;
  end
endmodule
